// ==== ptid_cfg.svh ====
`ifndef PTID_CFG_SVH
`define PTID_CFG_SVH
// configuration offsets, as byte addresses of the configuration word
`define PTID_OFS_BAR0        8'h10
`define PTID_OFS_BST0        8'h18
`define PTID_OFS_BST1        8'h1c
// field positions
`define PTID_BA_HI           31
`define PTID_BA_LO           16
`define PTID_MSG_BA_LO       12
`define PTID_PREFETCHABLE_BIT 3
`define PTID_SPACE_BIT       0
// prom enable bits
`define PTID_PROM_BIT_IMG0   5
`define PTID_PROM_BIT_IMG1   7
// reset values, the all-ones mask seed and the messaging reserved size
`define PTID_ZERO32          32'h0000_0000
`define PTID_ZERO16          16'h0000
`define PTID_ONES16          16'hffff
`define PTID_MSG_RSV_SIZE    32'h0000_1000
`endif

// ==== ptid_pkg.sv ====
package ptid_pkg;
    typedef logic [3:0]  ptid_size_code_t;
    typedef logic [31:0] ptid_word_t;
    typedef logic [7:0]  ptid_ofs_t;
    typedef logic [7:0]  ptid_byte_t;
endpackage : ptid_pkg

// ==== ptid_top.sv ====
`timescale 1ns/100ps
`include "ptid_cfg.svh"
module ptid_top (
    // clock and pci reset
    input  wire logic                 CLK_SYS_I,
    input  wire logic                 RST_I,
    // power-up straps (asynchronous pins)
    input  wire logic                 PROM_PRESENT_STRAP_I,
    input  wire logic                 CONFIG_HOLD_OPTION_I,
    // prom loader
    input  wire logic                 PROM_LOAD_DONE_I,
    input  wire ptid_pkg::ptid_byte_t PROM_BYTE7_I,
    input  wire ptid_pkg::ptid_byte_t PROM_BYTE8_I,
    input  wire logic                 PROM_PREF0_I,
    input  wire logic                 PROM_PREF1_I,
    input  wire logic                 PROM_PAS0_I,
    input  wire logic                 PROM_PAS1_I,
    // image control fields and messaging control
    input  wire ptid_pkg::ptid_size_code_t BLOCK_SIZE_CODE0_I,
    input  wire ptid_pkg::ptid_size_code_t BLOCK_SIZE_CODE1_I,
    input  wire logic                 LOCAL_PREFETCH_ENABLE0_I,
    input  wire logic                 LOCAL_PREFETCH_ENABLE1_I,
    input  wire logic                 MESSAGING_ENABLE_I,
    // pci configuration access
    input  wire logic                 CFG_WR_I,
    input  wire logic                 CFG_RD_I,
    input  wire ptid_pkg::ptid_ofs_t  CFG_OFS_I,
    input  wire ptid_pkg::ptid_word_t CFG_WDATA_I,
    input  wire logic [3:0]           CFG_BE_I,
    output ptid_pkg::ptid_word_t      CFG_RDATA_O,
    output logic                      CFG_RVALID_O,
    // local bus prefetchable flag writes
    input  wire logic                 LB_PREFETCHABLE_FLAG_WR0_I,
    input  wire logic                 LB_PREFETCHABLE_FLAG_WR1_I,
    input  wire logic                 LB_PREFETCHABLE_FLAG_DATA_I,
    // pci address phase decode
    input  wire logic                 ADDR_PHASE_I,
    input  wire ptid_pkg::ptid_word_t PCI_AD_I,
    output logic                      HIT_IMG0_O,
    output logic                      HIT_IMG1_O,
    output logic                      HIT_MSG_REG_O,
    output logic                      HIT_MSG_WIN_O,
    output logic                      PREFETCH_IMG0_O,
    output logic                      PREFETCH_IMG1_O,
    // enable status
    output logic                      IMG0_ENABLED_O,
    output logic                      IMG1_ENABLED_O
);
    import ptid_pkg::*;

    // register map seen by the host, by byte offset of the configuration word:
    //   010  image 0 base while messaging is on, otherwise not held here
    //   018  image 0 base while messaging is off, messaging base while it is on
    //   01c  image 1 base in either mode
    // each image base word: bits 31..16 base, bit 3 prefetchable, bit 0 space
    // messaging base word: bits 31..12 base, everything below reads zero
    //
    // timing: accesses are taken on the edge where the strobe stands high,
    // read data and its valid pulse follow one cycle later, and every decode
    // hit is registered, so it also answers one cycle after its address phase
    //
    // hazard: the straps are only looked at once per reset; a board that
    // drives them late must hold reset until they are stable

    // writable mask: bits at or above the block-size boundary, used twice
    // a shift of all ones keeps the mask contiguous from bit 15 downwards,
    // so the host sizing write always reads back a run of leading ones
    function automatic logic [15:0] ptid_size_mask(input ptid_size_code_t code);
        ptid_size_mask = `PTID_ONES16 << code;
    endfunction : ptid_size_mask

    // hit when masked upper address equals masked base
    // base bits below the boundary are zero unless the code was raised after the write, but the address bits are
    // not, so the mask is applied to the difference rather than to the base
    function automatic logic ptid_match(input logic [15:0] base, input logic [15:0] ad,
                                        input ptid_size_code_t code);
        ptid_match = ((base ^ ad) & ptid_size_mask(code)) == `PTID_ZERO16;
    endfunction : ptid_match

    // the straps are board pins with no relation to the pci clock; two
    // flip-flops give a metastable first stage a full cycle to settle
    // strap synchronisers: first stage feeds only the second
    logic [1:0] prom_strap_sync_reg;
    logic [1:0] hold_sync_reg;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            prom_strap_sync_reg <= 2'h0;
            hold_sync_reg       <= 2'h0;
        end else begin
            prom_strap_sync_reg <= {prom_strap_sync_reg[0], PROM_PRESENT_STRAP_I};
            hold_sync_reg       <= {hold_sync_reg[0], CONFIG_HOLD_OPTION_I};
        end
    end

    // straps are captured once, in the first cycles after reset release
    // a two-bit counter is enough: the capture happens on the third edge,
    // once the synchroniser has filled, and then the counter parks at three
    // limitation: a strap that changes later is ignored until the next reset
    logic [1:0] strap_cnt_reg;
    logic       prom_strap_reg;
    logic       hold_reg;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            strap_cnt_reg  <= 2'h0;
            prom_strap_reg <= 1'b0;
            hold_reg       <= 1'b0;
        end else if (strap_cnt_reg != 2'h3) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == 2'h2) begin
                prom_strap_reg <= prom_strap_sync_reg[1];
                hold_reg       <= hold_sync_reg[1];
            end
        end
    end

    // enables settle when prom loading completes; the hold option needs no prom
    // the enables are re-evaluated every cycle, so a loader that drops its
    // done flag also drops the images it had opened; nothing is sticky here
    logic img0_en_reg;
    logic img1_en_reg;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            img0_en_reg <= 1'b0;
            img1_en_reg <= 1'b0;
        end else begin
            img0_en_reg <= hold_reg |
                (prom_strap_reg & PROM_LOAD_DONE_I & PROM_BYTE7_I[`PTID_PROM_BIT_IMG0]);
            img1_en_reg <= hold_reg |
                (prom_strap_reg & PROM_LOAD_DONE_I & PROM_BYTE8_I[`PTID_PROM_BIT_IMG1]);
        end
    end

    // decode: image 0 answers at 010 when messaging is on, messaging window at 018
    // the offset compare is combinational and is only used on the same edge
    // that takes the access, so no register stage is needed in front of it
    // offsets other than the three handled here fall through and read zero
    logic sel_img0;
    logic sel_img1;
    logic sel_msg;
    assign sel_img0 = MESSAGING_ENABLE_I ? (CFG_OFS_I == `PTID_OFS_BAR0)
                                         : (CFG_OFS_I == `PTID_OFS_BST0);
    assign sel_msg  = MESSAGING_ENABLE_I & (CFG_OFS_I == `PTID_OFS_BST0);
    assign sel_img1 = (CFG_OFS_I == `PTID_OFS_BST1);

    // image base fields, reset to zero by pci reset
    // only the upper half of the word is base storage; bits 15..0 are the prefetchable and space flags or hardwired zeros
    // and are rebuilt when the read word is assembled
    logic [15:0] base0_reg;
    logic [15:0] base1_reg;
    logic [15:0] wdata_hi;
    logic [1:0]  be_hi;
    logic [15:0] wr_mask0;
    logic [15:0] wr_mask1;
    assign wdata_hi = CFG_WDATA_I[`PTID_BA_HI:`PTID_BA_LO];
    assign be_hi    = CFG_BE_I[3:2];
    // masks follow the live block-size codes; a code change does not clear
    // bits already stored, the next write does
    assign wr_mask0 = ptid_size_mask(BLOCK_SIZE_CODE0_I);
    assign wr_mask1 = ptid_size_mask(BLOCK_SIZE_CODE1_I);
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            base0_reg <= `PTID_ZERO16;
            base1_reg <= `PTID_ZERO16;
        end else begin
            // disabled images ignore writes entirely
            if (CFG_WR_I && sel_img0 && img0_en_reg) begin
                if (be_hi[1])
                    base0_reg[15:8] <= wdata_hi[15:8] & wr_mask0[15:8];
                if (be_hi[0])
                    base0_reg[7:0]  <= wdata_hi[7:0] & wr_mask0[7:0];
            end
            if (CFG_WR_I && sel_img1 && img1_en_reg) begin
                if (be_hi[1])
                    base1_reg[15:8] <= wdata_hi[15:8] & wr_mask1[15:8];
                if (be_hi[0])
                    base1_reg[7:0]  <= wdata_hi[7:0] & wr_mask1[7:0];
            end
        end
    end

    // messaging base: no pci reset, so it is kept across resets; power-up value zero
    // only the power-up value clears it, so a host that restarts the bus
    // keeps its messaging window without having to reprogram it
    logic [19:0] msg_base_reg = 20'h0_0000;
    always_ff @(posedge CLK_SYS_I) begin
        if (CFG_WR_I && sel_msg) begin
            if (CFG_BE_I[3])
                msg_base_reg[19:12] <= CFG_WDATA_I[31:24];
            if (CFG_BE_I[2])
                msg_base_reg[11:4]  <= CFG_WDATA_I[23:16];
            if (CFG_BE_I[1])
                msg_base_reg[3:0]   <= CFG_WDATA_I[15:12];
        end
    end

    // prefetchable flags: prom load, then local bus writes
    // the load is taken on the rising edge of the done flag only; a level
    // test would keep overwriting local bus writes for as long as it stands
    // when both come in one cycle the prom value wins and the write is lost
    logic pref0_reg;
    logic pref1_reg;
    logic load_done_d_reg;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            pref0_reg       <= 1'b0;
            pref1_reg       <= 1'b0;
            load_done_d_reg <= 1'b0;
        end else begin
            load_done_d_reg <= PROM_LOAD_DONE_I;
            if (PROM_LOAD_DONE_I && !load_done_d_reg && prom_strap_reg) begin
                pref0_reg <= PROM_PREF0_I;
                pref1_reg <= PROM_PREF1_I;
            end else begin
                if (LB_PREFETCHABLE_FLAG_WR0_I)
                    pref0_reg <= LB_PREFETCHABLE_FLAG_DATA_I;
                if (LB_PREFETCHABLE_FLAG_WR1_I)
                    pref1_reg <= LB_PREFETCHABLE_FLAG_DATA_I;
            end
        end
    end

    // space indicators come from the prom only; pci cannot write them
    // an image marked as i/o space never raises its own hit below; the messaging window hit ignores the image 0 space flag
    logic pas0_reg;
    logic pas1_reg;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            pas0_reg <= 1'b0;
            pas1_reg <= 1'b0;
        end else if (PROM_LOAD_DONE_I && !load_done_d_reg && prom_strap_reg) begin
            pas0_reg <= PROM_PAS0_I;
            pas1_reg <= PROM_PAS1_I;
        end
    end

    // read words: hardwired bits are zero, sub-boundary bits too unless the code was raised after the write
    // bits 15..4 and 2..1 of the image words are never driven, which keeps the hardwired zeros
    // out of every write path
    ptid_word_t img0_word;
    ptid_word_t img1_word;
    ptid_word_t msg_word;
    always_comb begin
        img0_word = `PTID_ZERO32;
        img1_word = `PTID_ZERO32;
        msg_word  = `PTID_ZERO32;
        if (img0_en_reg) begin
            img0_word[`PTID_BA_HI:`PTID_BA_LO] = base0_reg;
            img0_word[`PTID_PREFETCHABLE_BIT]  = pref0_reg;
            img0_word[`PTID_SPACE_BIT]         = pas0_reg;
        end
        if (img1_en_reg) begin
            img1_word[`PTID_BA_HI:`PTID_BA_LO] = base1_reg;
            img1_word[`PTID_PREFETCHABLE_BIT]  = pref1_reg;
            img1_word[`PTID_SPACE_BIT]         = pas1_reg;
        end
        msg_word[`PTID_BA_HI:`PTID_MSG_BA_LO] = msg_base_reg;                // space bit stays 0
    end

    // registered read answer, one cycle after the request
    // the data bus returns to zero between reads so that a stale word can
    // never be mistaken for an answer by a host that samples late
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            CFG_RDATA_O  <= `PTID_ZERO32;
            CFG_RVALID_O <= 1'b0;
        end else begin
            CFG_RVALID_O <= CFG_RD_I;
            if (!CFG_RD_I)
                CFG_RDATA_O <= `PTID_ZERO32;
            else if (sel_img0)
                CFG_RDATA_O <= img0_word;
            else if (sel_msg)
                CFG_RDATA_O <= msg_word;
            else if (sel_img1)
                CFG_RDATA_O <= img1_word;
            else
                CFG_RDATA_O <= `PTID_ZERO32;
        end
    end

    // address-phase decode; messaging window splits into register page and local window
    // the reserved test subtracts the base rather than comparing fields, which
    // stays correct if the reserved size is ever made larger than one page
    // the hits are registered, so a decode answers one cycle after the phase
    logic msg_match;
    logic msg_in_rsv;
    assign msg_match  = (PCI_AD_I[`PTID_BA_HI:`PTID_MSG_BA_LO] == msg_base_reg);
    assign msg_in_rsv = (PCI_AD_I[`PTID_BA_HI:0] - {msg_base_reg, 12'h000})
                        < `PTID_MSG_RSV_SIZE;
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            HIT_IMG0_O    <= 1'b0;
            HIT_IMG1_O    <= 1'b0;
            HIT_MSG_REG_O <= 1'b0;
            HIT_MSG_WIN_O <= 1'b0;
        end else begin
            HIT_IMG0_O <= ADDR_PHASE_I && img0_en_reg && !pas0_reg &&
                ptid_match(base0_reg, PCI_AD_I[`PTID_BA_HI:`PTID_BA_LO], BLOCK_SIZE_CODE0_I);
            HIT_IMG1_O <= ADDR_PHASE_I && img1_en_reg && !pas1_reg &&
                ptid_match(base1_reg, PCI_AD_I[`PTID_BA_HI:`PTID_BA_LO], BLOCK_SIZE_CODE1_I);
            // only the 4K page at the messaging base is reserved; the rest of the image 0 window is local memory
            HIT_MSG_REG_O <= ADDR_PHASE_I && MESSAGING_ENABLE_I && msg_match;
            HIT_MSG_WIN_O <= ADDR_PHASE_I && MESSAGING_ENABLE_I && img0_en_reg && !msg_in_rsv &&
                ptid_match(base0_reg, PCI_AD_I[`PTID_BA_HI:`PTID_BA_LO], BLOCK_SIZE_CODE0_I);
        end
    end

    // prefetch needs both the prefetchable flag and the control enable
    // the flag only tells the host that reads are harmless; the local side
    // still decides whether to read ahead, through its own enable
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            PREFETCH_IMG0_O <= 1'b0;
            PREFETCH_IMG1_O <= 1'b0;
            IMG0_ENABLED_O  <= 1'b0;
            IMG1_ENABLED_O  <= 1'b0;
        end else begin
            PREFETCH_IMG0_O <= pref0_reg & LOCAL_PREFETCH_ENABLE0_I;
            PREFETCH_IMG1_O <= pref1_reg & LOCAL_PREFETCH_ENABLE1_I;
            IMG0_ENABLED_O  <= img0_en_reg;
            IMG1_ENABLED_O  <= img1_en_reg;
        end
    end

endmodule : ptid_top

// ==== ptid_top_chk.sv ====
`timescale 1ns/100ps
module ptid_top_chk (
    // clock and reset
    input wire logic                 CLK_SYS_I,
    input wire logic                 RST_I,
    // controls
    input wire ptid_pkg::ptid_size_code_t BLOCK_SIZE_CODE1_I,
    input wire logic                 LOCAL_PREFETCH_ENABLE0_I,
    input wire logic                 LOCAL_PREFETCH_ENABLE1_I,
    input wire logic                 MESSAGING_ENABLE_I,
    input wire logic                 CFG_RD_I,
    input wire ptid_pkg::ptid_ofs_t  CFG_OFS_I,
    input wire logic                 ADDR_PHASE_I,
    // results
    input wire ptid_pkg::ptid_word_t CFG_RDATA_O,
    input wire logic                 CFG_RVALID_O,
    input wire logic                 HIT_IMG1_O,
    input wire logic                 HIT_MSG_REG_O,
    input wire logic                 HIT_MSG_WIN_O,
    input wire logic                 PREFETCH_IMG0_O,
    input wire logic                 PREFETCH_IMG1_O,
    input wire logic                 IMG1_ENABLED_O
);
    import ptid_pkg::*;
    logic [15:0] low1_reg;
    // base bits under the size boundary, one cycle late to line up with read data
    always_ff @(posedge CLK_SYS_I) begin
        low1_reg <= (16'h0001 << BLOCK_SIZE_CODE1_I) - 16'h0001;
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    a_read_answers: assert property (CFG_RD_I |=> CFG_RVALID_O)
        else $error("read got no answer");
    a_idle_quiet: assert property (!CFG_RD_I |=> !CFG_RVALID_O && CFG_RDATA_O == 32'h0000_0000)
        else $error("read data without a read");
    a_hit_from_phase: assert property (HIT_IMG1_O |-> $past(ADDR_PHASE_I))
        else $error("hit without address phase");
    a_hit_when_on: assert property (HIT_IMG1_O |-> IMG1_ENABLED_O)
        else $error("hit on disabled image");
    a_off_reads_zero: assert property (CFG_RD_I && CFG_OFS_I == 8'h1c && !IMG1_ENABLED_O
        |=> CFG_RDATA_O == 32'h0000_0000)
        else $error("disabled image read not zero");
    a_size_bits_zero: assert property (CFG_RD_I && CFG_OFS_I == 8'h1c
        |=> (CFG_RDATA_O[31:16] & low1_reg) == 16'h0000)
        else $error("base bit below boundary set");
    a_fixed_zeros: assert property (CFG_RD_I && CFG_OFS_I == 8'h1c
        |=> CFG_RDATA_O[15:4] == 12'h000 && CFG_RDATA_O[2:1] == 2'b00)
        else $error("hardwired bit set");
    a_msg_low_zero: assert property (MESSAGING_ENABLE_I && CFG_RD_I && CFG_OFS_I == 8'h18
        |=> CFG_RDATA_O[11:0] == 12'h000)
        else $error("messaging base low bits set");
    a_msg_split: assert property (!(HIT_MSG_REG_O && HIT_MSG_WIN_O))
        else $error("reserved and window hit together");
    a_msg_off: assert property (!MESSAGING_ENABLE_I |=> !HIT_MSG_REG_O && !HIT_MSG_WIN_O)
        else $error("messaging hit while disabled");
    a_prefetchable_flag_gate0: assert property (!LOCAL_PREFETCH_ENABLE0_I |=> !PREFETCH_IMG0_O)
        else $error("image 0 prefetch without enable");
    a_prefetchable_flag_gate1: assert property (!LOCAL_PREFETCH_ENABLE1_I |=> !PREFETCH_IMG1_O)
        else $error("image 1 prefetch without enable");
    c_hit1: cover property (HIT_IMG1_O);
    c_pref1: cover property (PREFETCH_IMG1_O);
    c_pref0: cover property (PREFETCH_IMG0_O);
endmodule : ptid_top_chk

// ==== ptid_host.sv ====
`timescale 1ns/100ps
module ptid_host (
    // clock
    input  wire logic                 clk_i,
    // configuration cycles
    output logic                      cfg_wr_o,
    output logic                      cfg_rd_o,
    output ptid_pkg::ptid_ofs_t       cfg_ofs_o,
    output ptid_pkg::ptid_word_t      cfg_wdata_o,
    output logic [3:0]                cfg_be_o,
    input  wire ptid_pkg::ptid_word_t cfg_rdata_i,
    // address phases
    output logic                      addr_phase_o,
    output ptid_pkg::ptid_word_t      pci_ad_o
);
    import ptid_pkg::*;
    // idle bus; released lines carry the inverse so stale values never match
    initial begin
        cfg_wr_o = 1'b0;
        cfg_rd_o = 1'b0;
        cfg_ofs_o = 8'h00;
        cfg_wdata_o = 32'h0000_0000;
        cfg_be_o = 4'hf;
        addr_phase_o = 1'b0;
        pci_ad_o = 32'h0000_0000;
    end
    task automatic cfg_write(input ptid_ofs_t ofs, input ptid_word_t d);
        @(posedge clk_i);
        cfg_wr_o <= 1'b1;
        cfg_ofs_o <= ofs;
        cfg_wdata_o <= d;
        @(posedge clk_i);
        cfg_wr_o <= 1'b0;
        cfg_wdata_o <= ~d;
    endtask : cfg_write
    task automatic cfg_read(input ptid_ofs_t ofs, output ptid_word_t d);
        @(posedge clk_i);
        cfg_rd_o <= 1'b1;
        cfg_ofs_o <= ofs;
        @(posedge clk_i);
        cfg_rd_o <= 1'b0;
        #1 d = cfg_rdata_i;
    endtask : cfg_read
    task automatic addr_cycle(input ptid_word_t a);
        @(posedge clk_i);
        addr_phase_o <= 1'b1;
        pci_ad_o <= a;
        @(posedge clk_i);
        addr_phase_o <= 1'b0;
        pci_ad_o <= ~a;
        #1;
    endtask : addr_cycle
endmodule : ptid_host

// ==== ptid_top_tb.sv ====
`timescale 1ns/100ps
module ptid_top_tb;
    import ptid_pkg::*;
    logic CLK_SYS_I = 1'b0, RST_I = 1'b1, PROM_PRESENT_STRAP_I = 1'b1, CONFIG_HOLD_OPTION_I = 1'b0;
    logic PROM_LOAD_DONE_I = 1'b0, PROM_PREF0_I = 1'b1, PROM_PREF1_I = 1'b1;
    logic PROM_PAS0_I = 1'b0, PROM_PAS1_I = 1'b0, MESSAGING_ENABLE_I = 1'b0;
    logic LOCAL_PREFETCH_ENABLE0_I = 1'b0, LOCAL_PREFETCH_ENABLE1_I = 1'b0;
    logic LB_PREFETCHABLE_FLAG_WR0_I = 1'b0, LB_PREFETCHABLE_FLAG_WR1_I = 1'b0, LB_PREFETCHABLE_FLAG_DATA_I = 1'b0;
    ptid_byte_t PROM_BYTE7_I = 8'h20, PROM_BYTE8_I = 8'h7f;
    ptid_size_code_t BLOCK_SIZE_CODE0_I = 4'h0, BLOCK_SIZE_CODE1_I = 4'h0;
    logic       CFG_WR_I, CFG_RD_I, ADDR_PHASE_I, CFG_RVALID_O, HIT_IMG0_O, HIT_IMG1_O;
    logic       HIT_MSG_REG_O, HIT_MSG_WIN_O, PREFETCH_IMG0_O, PREFETCH_IMG1_O;
    logic       IMG0_ENABLED_O, IMG1_ENABLED_O;
    logic [3:0] CFG_BE_I;
    ptid_ofs_t  CFG_OFS_I;
    ptid_word_t CFG_WDATA_I, PCI_AD_I, CFG_RDATA_O, got;
    int         n_errors = 0, tests_run = 0, cycles = 0;
    // 25 MHz clock
    always #20 CLK_SYS_I = ~CLK_SYS_I;
    ptid_top u_ptid_top (.CLK_SYS_I, .RST_I, .PROM_PRESENT_STRAP_I, .CONFIG_HOLD_OPTION_I,
        .PROM_LOAD_DONE_I, .PROM_BYTE7_I, .PROM_BYTE8_I, .PROM_PREF0_I, .PROM_PREF1_I,
        .PROM_PAS0_I, .PROM_PAS1_I, .BLOCK_SIZE_CODE0_I, .BLOCK_SIZE_CODE1_I,
        .LOCAL_PREFETCH_ENABLE0_I, .LOCAL_PREFETCH_ENABLE1_I, .MESSAGING_ENABLE_I,
        .CFG_WR_I, .CFG_RD_I, .CFG_OFS_I, .CFG_WDATA_I, .CFG_BE_I, .CFG_RDATA_O,
        .CFG_RVALID_O, .LB_PREFETCHABLE_FLAG_WR0_I, .LB_PREFETCHABLE_FLAG_WR1_I, .LB_PREFETCHABLE_FLAG_DATA_I, .ADDR_PHASE_I,
        .PCI_AD_I, .HIT_IMG0_O, .HIT_IMG1_O, .HIT_MSG_REG_O, .HIT_MSG_WIN_O,
        .PREFETCH_IMG0_O, .PREFETCH_IMG1_O, .IMG0_ENABLED_O, .IMG1_ENABLED_O);
    ptid_host u_ptid_host (.clk_i(CLK_SYS_I), .cfg_wr_o(CFG_WR_I), .cfg_rd_o(CFG_RD_I),
        .cfg_ofs_o(CFG_OFS_I), .cfg_wdata_o(CFG_WDATA_I), .cfg_be_o(CFG_BE_I),
        .cfg_rdata_i(CFG_RDATA_O), .addr_phase_o(ADDR_PHASE_I), .pci_ad_o(PCI_AD_I));
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string name, input ptid_word_t exp, input ptid_word_t seen);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rchk(input string name, input ptid_ofs_t ofs, input ptid_word_t exp);
        u_ptid_host.cfg_read(ofs, got);
        check(name, exp, got);
    endtask : rchk
    // straps are held through reset, then the prom load completes
    task automatic do_reset(input logic strap, input logic hold, input logic msg);
        @(posedge CLK_SYS_I);
        RST_I <= 1'b1;
        PROM_PRESENT_STRAP_I <= strap;
        CONFIG_HOLD_OPTION_I <= hold;
        MESSAGING_ENABLE_I <= msg;
        PROM_LOAD_DONE_I <= 1'b0;
        repeat (6) @(posedge CLK_SYS_I);
        RST_I <= 1'b0;
        repeat (5) @(posedge CLK_SYS_I);
        PROM_LOAD_DONE_I <= 1'b1;
        repeat (3) @(posedge CLK_SYS_I);
        #1;
    endtask : do_reset
    // local bus write of a prefetchable flag, then prefetch output seen
    task automatic lb_prefetchable_flag(input logic img, input logic val, input logic exp);
        LB_PREFETCHABLE_FLAG_DATA_I <= val;
        LB_PREFETCHABLE_FLAG_WR0_I <= !img;
        LB_PREFETCHABLE_FLAG_WR1_I <= img;
        @(posedge CLK_SYS_I);
        LB_PREFETCHABLE_FLAG_WR0_I <= 1'b0;
        LB_PREFETCHABLE_FLAG_WR1_I <= 1'b0;
        repeat (2) @(posedge CLK_SYS_I);
        #1 check("prefetch", 32'(exp), 32'(img ? PREFETCH_IMG1_O : PREFETCH_IMG0_O));
    endtask : lb_prefetchable_flag
    // hang guard, far above the roughly 160 cycles the sequence needs
    always @(posedge CLK_SYS_I) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        // prom strap on: byte 7 bit 5 set, byte 8 has every bit but 7
        do_reset(1'b1, 1'b0, 1'b0);
        check("img0_en", 32'h1, 32'(IMG0_ENABLED_O));
        check("img1_en", 32'h0, 32'(IMG1_ENABLED_O));
        rchk("img0_reset", 8'h18, 32'h0000_0008);
        // sizing runs after the prom load, one pass per block size code
        for (int i = 0; i < 16; i++) begin
            BLOCK_SIZE_CODE0_I <= 4'(i);
            u_ptid_host.cfg_write(8'h18, 32'hffff_ffff);
            rchk("img0_size", 8'h18, {16'hffff << i, 16'h0008});
        end
        u_ptid_host.cfg_write(8'h1c, 32'hffff_ffff);
        rchk("img1_off", 8'h1c, 32'h0000_0000);
        BLOCK_SIZE_CODE0_I <= 4'h4;
        u_ptid_host.cfg_write(8'h18, 32'h1234_5678);
        rchk("img0_base", 8'h18, 32'h1230_0008);
        u_ptid_host.addr_cycle(32'h123f_fffc);
        check("hit_in", 32'h1, 32'(HIT_IMG0_O));
        u_ptid_host.addr_cycle(32'h1240_0000);
        check("hit_out", 32'h0, 32'(HIT_IMG0_O));
        LOCAL_PREFETCH_ENABLE0_I <= 1'b1;
        lb_prefetchable_flag(1'b0, 1'b1, 1'b1);
        lb_prefetchable_flag(1'b0, 1'b0, 1'b0);
        // hold option with messaging: both images on, image 0 moved down
        do_reset(1'b0, 1'b1, 1'b1);
        check("hold_en", 32'h3, 32'({IMG0_ENABLED_O, IMG1_ENABLED_O}));
        BLOCK_SIZE_CODE0_I <= 4'hf;
        u_ptid_host.cfg_write(8'h10, 32'hffff_ffff);
        rchk("img0_moved", 8'h10, 32'h8000_0000);
        u_ptid_host.cfg_write(8'h18, 32'habcd_ef12);
        rchk("msg_base", 8'h18, 32'habcd_e000);
        // reserved page of the window, then a local part below it
        u_ptid_host.addr_cycle(32'habcd_e010);
        check("msg_rsv", 32'h2, 32'({HIT_MSG_REG_O, HIT_MSG_WIN_O}));
        u_ptid_host.addr_cycle(32'h8000_2000);
        check("msg_win", 32'h1, 32'({HIT_MSG_REG_O, HIT_MSG_WIN_O}));
        BLOCK_SIZE_CODE1_I <= 4'hf;
        u_ptid_host.cfg_write(8'h1c, 32'h8000_0000);
        u_ptid_host.addr_cycle(32'h9000_0000);
        check("hit1", 32'h1, 32'(HIT_IMG1_O));
        LOCAL_PREFETCH_ENABLE1_I <= 1'b1;
        lb_prefetchable_flag(1'b1, 1'b1, 1'b1);
        LOCAL_PREFETCH_ENABLE1_I <= 1'b0;
        lb_prefetchable_flag(1'b1, 1'b1, 1'b0);
        // no strap, no hold: both off, messaging base survives the reset
        do_reset(1'b0, 1'b0, 1'b1);
        check("none_en", 32'h0, 32'({IMG0_ENABLED_O, IMG1_ENABLED_O}));
        rchk("msg_kept", 8'h18, 32'habcd_e000);
        u_ptid_host.cfg_write(8'h10, 32'hffff_ffff);
        rchk("img0_off", 8'h10, 32'h0000_0000);
        rchk("unmapped", 8'h04, 32'h0000_0000);
        close_out();
    end
endmodule : ptid_top_tb
bind ptid_top ptid_top_chk u_ptid_top_chk (.CLK_SYS_I, .RST_I, .BLOCK_SIZE_CODE1_I,
    .LOCAL_PREFETCH_ENABLE0_I, .LOCAL_PREFETCH_ENABLE1_I, .MESSAGING_ENABLE_I, .CFG_RD_I,
    .CFG_OFS_I, .ADDR_PHASE_I, .CFG_RDATA_O, .CFG_RVALID_O, .HIT_IMG1_O, .HIT_MSG_REG_O,
    .HIT_MSG_WIN_O, .PREFETCH_IMG0_O, .PREFETCH_IMG1_O, .IMG1_ENABLED_O);
